// >>> rtl/fpda_arbiter.sv
// Duty arbitration for two fan outputs: ramps, manual override, spin-up and readback.
`timescale 1ns/1ps
`default_nettype none
`include "fpda_regs.svh"
module fpda_arbiter
   import fpda_pkg::*;
#(
   parameter int TICK_CYC = `FPDA_TICK_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] regulator_hot,
   input wire logic [1:0] processor_hot_over,
   input wire logic [1:0] processor_hot_sample,
   input wire logic [3:0] regulator_hot_bind,
   input wire logic [3:0] processor_hot_bind,
   input wire logic [1:0] forced_full,
   input wire logic [1:0] manual_enable,
   input wire logic [31:0] auto_duty,
   input wire logic [31:0] spinup_duty,
   input wire logic [15:0] spinup_ticks,
   input wire logic [15:0] ramp_ticks,
   input wire logic [15:0] ramp_step,
   output logic [31:0] final_duty,
   output logic [1:0] spinup_active
);

   function automatic fpda_duty_t dmax(input fpda_duty_t a, input fpda_duty_t b);
      dmax = (a > b) ? a : b;
   endfunction
   function automatic fpda_duty_t add_sat(input fpda_duty_t a, input fpda_duty_t s);
      logic [16:0] sum;
      sum = {1'b0, a} + {1'b0, s};
      add_sat = sum[16] ? `FPDA_DUTY_FULL : sum[15:0];
   endfunction
   function automatic fpda_duty_t sub_sat(input fpda_duty_t a, input fpda_duty_t s);
      sub_sat = (a > s) ? a - s : `FPDA_DUTY_ZERO;
   endfunction

   // Input synchronisers; the hot pins are asynchronous.
   logic [1:0] vr_meta_ff, vr_ff, ph_meta_ff, ph_ff, phs_meta_ff, phs_ff, phs_d_ff;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         vr_meta_ff <= 2'h0;
         vr_ff <= 2'h0;
         ph_meta_ff <= 2'h0;
         ph_ff <= 2'h0;
         phs_meta_ff <= 2'h0;
         phs_ff <= 2'h0;
         phs_d_ff <= 2'h0;
      end
      else
      begin
         vr_meta_ff <= regulator_hot;
         vr_ff <= vr_meta_ff;
         ph_meta_ff <= processor_hot_over;
         ph_ff <= ph_meta_ff;
         phs_meta_ff <= processor_hot_sample;
         phs_ff <= phs_meta_ff;
         phs_d_ff <= phs_ff;
      end
   end

   // The processor-hot trigger only changes when a new sample is taken.
   logic [1:0] ph_trig_ff;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         ph_trig_ff <= 2'h0;
      else
         for (int i = 0; i < 2; i++)
            if (phs_ff[i] && !phs_d_ff[i])
               ph_trig_ff[i] <= ph_ff[i];
   end

   // Millisecond tick divider shared by ramps and spin-up.
   logic [31:0] tick_cnt_ff;
   logic tick_ff;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         tick_cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1));
         tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt_ff + 32'h1;
      end
   end

   // Override registers, one pair per output.
   logic [7:0] ovr_lo_ff [2];
   logic [7:0] ovr_hi_ff [2];
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ovr_lo_ff[0] <= `FPDA_RESET_BYTE;
         ovr_hi_ff[0] <= `FPDA_RESET_BYTE;
         ovr_lo_ff[1] <= `FPDA_RESET_BYTE;
         ovr_hi_ff[1] <= `FPDA_RESET_BYTE;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `FPDA_ADDR_OVR1_LO: ovr_lo_ff[0] <= reg_wdata;
            `FPDA_ADDR_OVR1_HI: ovr_hi_ff[0] <= reg_wdata;
            `FPDA_ADDR_OVR2_LO: ovr_lo_ff[1] <= reg_wdata;
            `FPDA_ADDR_OVR2_HI: ovr_hi_ff[1] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Ramp state: index 0,1 regulator-hot per output; 2,3 processor-hot per output.
   fpda_ramp_t ramp_st_ff [4];
   fpda_duty_t ramp_val_ff [4];
   logic [15:0] ramp_cnt_ff [4];
   fpda_duty_t base [2];
   fpda_duty_t fin [2];
   logic [3:0] ramp_trig;
   logic [3:0] ramp_bound;

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         ramp_trig[c] = |(vr_ff & regulator_hot_bind[c*2 +: 2]);
         ramp_trig[c+2] = |(ph_trig_ff & processor_hot_bind[c*2 +: 2]);
         ramp_bound[c] = |regulator_hot_bind[c*2 +: 2];
         ramp_bound[c+2] = |processor_hot_bind[c*2 +: 2];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         for (int r = 0; r < 4; r++)
         begin
            ramp_st_ff[r] <= FPDA_RAMP_OFF;
            ramp_val_ff[r] <= `FPDA_DUTY_ZERO;
            ramp_cnt_ff[r] <= 16'h0;
         end
      end
      else
      begin
         for (int r = 0; r < 4; r++)
         begin
            case (ramp_st_ff[r])
               FPDA_RAMP_OFF:
                  if (ramp_trig[r] && ramp_bound[r])
                  begin
                     ramp_st_ff[r] <= FPDA_RAMP_ON;
                     ramp_val_ff[r] <= add_sat(base[r%2], ramp_step);
                     ramp_cnt_ff[r] <= 16'h0;
                  end
               FPDA_RAMP_ON:
                  if (!ramp_trig[r] && ramp_val_ff[r] < base[r%2])
                     ramp_st_ff[r] <= FPDA_RAMP_OFF;
                  else if (tick_ff)
                  begin
                     if (ramp_cnt_ff[r] >= ramp_ticks)
                     begin
                        ramp_cnt_ff[r] <= 16'h0;
                        ramp_val_ff[r] <= ramp_trig[r] ? add_sat(ramp_val_ff[r], ramp_step)
                                                       : sub_sat(ramp_val_ff[r], ramp_step);
                     end
                     else
                        ramp_cnt_ff[r] <= ramp_cnt_ff[r] + 16'h1;
                  end
               default: ramp_st_ff[r] <= FPDA_RAMP_OFF;
            endcase
         end
      end
   end

   // Spin-up timers per output.
   logic [15:0] spin_cnt_ff [2];
   logic [1:0] spin_on_ff;
   logic [1:0] was_zero_ff;

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         fpda_duty_t hi;
         fpda_duty_t lo;
         hi = forced_full[c] ? `FPDA_DUTY_FULL : `FPDA_DUTY_ZERO;
         lo = auto_duty[c*16 +: 16];
         if (spin_on_ff[c])
            lo = dmax(lo, spinup_duty[c*16 +: 16]);
         if (manual_enable[c])
            lo = {ovr_hi_ff[c], ovr_lo_ff[c]};
         base[c] = dmax(hi, lo);
         for (int r = 0; r < 2; r++)
            if (ramp_st_ff[c + 2*r] == FPDA_RAMP_ON)
               hi = dmax(hi, ramp_val_ff[c + 2*r]);
         fin[c] = dmax(hi, lo);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         spin_on_ff <= 2'h0;
         was_zero_ff <= 2'h3;
         spin_cnt_ff[0] <= 16'h0;
         spin_cnt_ff[1] <= 16'h0;
      end
      else
      begin
         for (int c = 0; c < 2; c++)
         begin
            was_zero_ff[c] <= (fin[c] == `FPDA_DUTY_ZERO);
            if (was_zero_ff[c] && fin[c] != `FPDA_DUTY_ZERO && !manual_enable[c])
            begin
               spin_on_ff[c] <= 1'b1;
               spin_cnt_ff[c] <= 16'h0;
            end
            else if (spin_on_ff[c] && (manual_enable[c] || (tick_ff && spin_cnt_ff[c] >= spinup_ticks)))
               spin_on_ff[c] <= 1'b0;
            else if (spin_on_ff[c] && tick_ff)
               spin_cnt_ff[c] <= spin_cnt_ff[c] + 16'h1;
         end
      end
   end

   // Registered outputs and readback.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         final_duty <= 32'h0;
         spinup_active <= 2'h0;
      end
      else
      begin
         final_duty <= {fin[1], fin[0]};
         spinup_active <= spin_on_ff;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         reg_rdata <= `FPDA_RESET_BYTE;
      else if (reg_rd)
      begin
         case (reg_addr)
            `FPDA_ADDR_DUTY1: reg_rdata <= final_duty[15:8];
            `FPDA_ADDR_DUTY2: reg_rdata <= final_duty[31:24];
            `FPDA_ADDR_OVR1_LO: reg_rdata <= ovr_lo_ff[0];
            `FPDA_ADDR_OVR1_HI: reg_rdata <= ovr_hi_ff[0];
            `FPDA_ADDR_OVR2_LO: reg_rdata <= ovr_lo_ff[1];
            `FPDA_ADDR_OVR2_HI: reg_rdata <= ovr_hi_ff[1];
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   a_forced_full_out: assert property (@(posedge ref_clk) disable iff (reset)
      forced_full[0] |=> final_duty[15:0] == `FPDA_DUTY_FULL) else $error("forced full not applied");
   a_manual_floor: assert property (@(posedge ref_clk) disable iff (reset)
      manual_enable[0] |=> final_duty[15:0] >= $past({ovr_hi_ff[0], ovr_lo_ff[0]}))
      else $error("manual floor violated");
   a_spin_start: assert property (@(posedge ref_clk) disable iff (reset)
      (was_zero_ff[0] && fin[0] != `FPDA_DUTY_ZERO && !manual_enable[0]) |=> spin_on_ff[0])
      else $error("spin-up not triggered");
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
      (reg_rd && reg_addr > `FPDA_ADDR_OVR2_HI) |=> reg_rdata == 8'h00) else $error("reserved not zero");
   a_readback_duty: assert property (@(posedge ref_clk) disable iff (reset)
      (reg_rd && reg_addr == `FPDA_ADDR_DUTY1) |=> reg_rdata == $past(final_duty[15:8])) else $error("readback wrong");
   a_ramp_enable: assert property (@(posedge ref_clk) disable iff (reset)
      (ramp_st_ff[0] == FPDA_RAMP_OFF && ramp_trig[0] && ramp_bound[0])
      |=> ramp_st_ff[0] == FPDA_RAMP_ON && ramp_val_ff[0] == add_sat($past(base[0]), $past(ramp_step)))
      else $error("ramp enable wrong");
   a_ramp_disable: assert property (@(posedge ref_clk) disable iff (reset)
      (ramp_st_ff[2] == FPDA_RAMP_ON && !ramp_trig[2] && ramp_val_ff[2] < base[0])
      |=> ramp_st_ff[2] == FPDA_RAMP_OFF) else $error("ramp not disabled");
   a_manual_no_spin: assert property (@(posedge ref_clk) disable iff (reset)
      manual_enable[1] [*2] |=> !spin_on_ff[1]) else $error("spin-up during manual");
   a_override_write: assert property (@(posedge ref_clk) disable iff (reset)
      (reg_wr && reg_addr == `FPDA_ADDR_OVR2_LO) |=> ovr_lo_ff[1] == $past(reg_wdata)) else $error("override write lost");

endmodule
`default_nettype wire

// >>> rtl/fpda_regs.svh
// Register offsets, reset values and timing constants of the fan duty arbiter.
`ifndef FPDA_REGS_SVH
`define FPDA_REGS_SVH
`define FPDA_ADDR_DUTY1 8'h0A
`define FPDA_ADDR_DUTY2 8'h0B
`define FPDA_ADDR_OVR1_LO 8'h0C
`define FPDA_ADDR_OVR1_HI 8'h0D
`define FPDA_ADDR_OVR2_LO 8'h0E
`define FPDA_ADDR_OVR2_HI 8'h0F
`define FPDA_RESET_BYTE 8'h00
`define FPDA_DUTY_FULL 16'hFFFF
`define FPDA_DUTY_ZERO 16'h0000
`define FPDA_CLK_HZ 125000000
`define FPDA_TICK_US 1000
`define FPDA_TICK_CYC ((`FPDA_CLK_HZ / 1000000) * `FPDA_TICK_US)
`endif

// >>> rtl/fpda_pkg.sv
// Types shared by the fan duty arbiter.
package fpda_pkg;
   typedef logic [15:0] fpda_duty_t;
   typedef enum logic [1:0]
   {
      FPDA_RAMP_OFF = 2'b01,
      FPDA_RAMP_ON = 2'b10
   } fpda_ramp_t;
endpackage

// >>> tb/fpda_therm_model.sv
// Behavioural processor thermal source feeding the hot-measurement inputs.
`timescale 1ns/1ps
`default_nettype none
module fpda_therm_model
(
   input wire logic ref_clk,
   output logic [1:0] over,
   output logic [1:0] sample
);
   initial
   begin
      over = 2'b00;
      sample = 2'b00;
   end
   // The strobe rises only after the result level has settled, so the capture never sees a moving level.
   task automatic measure(input int idx, input logic hot);
      @(posedge ref_clk);
      over[idx] <= hot;
      repeat (3) @(posedge ref_clk);
      sample[idx] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sample[idx] <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the fan duty arbiter.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import fpda_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [1:0] regulator_hot = 2'b00;
   logic [3:0] regulator_hot_bind = 4'h0;
   logic [3:0] processor_hot_bind = 4'h0;
   logic [1:0] forced_full = 2'b00;
   logic [1:0] manual_enable = 2'b00;
   logic [31:0] auto_duty = 32'h0;
   logic [31:0] spinup_duty = 32'h8000_8000;
   logic [15:0] spinup_ticks = 16'h0001;
   logic [15:0] ramp_ticks = 16'h0000;
   logic [15:0] ramp_step = 16'h0100;
   logic [31:0] final_duty;
   logic [1:0] spinup_active;
   logic [1:0] ph_over;
   logic [1:0] ph_sample;
   int n_fail = 0;
   int n_compared = 0;
   always #4 ref_clk = ~ref_clk;
   fpda_therm_model u_therm (.ref_clk(ref_clk), .over(ph_over), .sample(ph_sample));
   fpda_arbiter #(.TICK_CYC(10)) u_dut (.ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .regulator_hot(regulator_hot),
      .processor_hot_over(ph_over), .processor_hot_sample(ph_sample), .regulator_hot_bind(regulator_hot_bind),
      .processor_hot_bind(processor_hot_bind), .forced_full(forced_full), .manual_enable(manual_enable),
      .auto_duty(auto_duty), .spinup_duty(spinup_duty), .spinup_ticks(spinup_ticks), .ramp_ticks(ramp_ticks),
      .ramp_step(ramp_step), .final_duty(final_duty), .spinup_active(spinup_active));
   task automatic chk(input string name, input fpda_duty_t exp, input fpda_duty_t got);
      n_compared++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg_%h", a), {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   // A wait that runs out its bound ends the run, since later steps would only pile up noise.
   task automatic wait_duty(input int idx, input fpda_duty_t exp, input int bound);
      int n;
      n = 0;
      while (final_duty[16*idx +: 16] !== exp && n < bound)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk($sformatf("final_duty%0d", idx), exp, final_duty[16*idx +: 16]);
      if (final_duty[16*idx +: 16] !== exp)
         give_verdict();
   endtask
   task automatic t_reset();
      for (int a = 8'h0A; a <= 8'h0F; a++)
         rd(a[7:0], 8'h00);
      rd(8'h20, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_spinup();
      @(posedge ref_clk);
      auto_duty <= 32'h0000_0100;
      wait_duty(0, 16'h8000, 20);
      chk("spinup_active0", 16'h0001, {15'h0, spinup_active[0]});
      wait_duty(0, 16'h0100, 200);
      chk("spinup_active", 16'h0000, {14'h0, spinup_active});
      chk("final_duty1", 16'h0000, final_duty[31:16]);
      $display("test spinup done");
   endtask
   task automatic t_override();
      @(posedge ref_clk);
      manual_enable <= 2'b01;
      wr(8'h0C, 8'h34);
      wr(8'h0D, 8'h56);
      wr(8'h0A, 8'hFF);
      wait_duty(0, 16'h5634, 20);
      chk("spinup_active", 16'h0000, {14'h0, spinup_active});
      rd(8'h0C, 8'h34);
      rd(8'h0D, 8'h56);
      rd(8'h0A, 8'h56);
      wr(8'h0D, 8'h00);
      wr(8'h0C, 8'h10);
      wait_duty(0, 16'h0010, 20);
      @(posedge ref_clk);
      forced_full <= 2'b01;
      wait_duty(0, 16'hFFFF, 20);
      rd(8'h0A, 8'hFF);
      @(posedge ref_clk);
      forced_full <= 2'b00;
      manual_enable <= 2'b00;
      wait_duty(0, 16'h0100, 20);
      $display("test override done");
   endtask
   task automatic t_ramp();
      @(posedge ref_clk);
      processor_hot_bind <= 4'b0001;
      auto_duty <= 32'h0000_1000;
      wait_duty(0, 16'h1000, 20);
      for (int k = 0; k < 2; k++)
      begin
         u_therm.measure(0, 1'b1);
         wait_duty(0, 16'h1100, 40);
         wait_duty(0, 16'h1200, 40);
         wait_duty(0, 16'h1300, 40);
         chk("final_duty1", 16'h0000, final_duty[31:16]);
         u_therm.measure(0, 1'b0);
         wait_duty(0, 16'h1200, 60);
         wait_duty(0, 16'h1000, 100);
         repeat (60) @(posedge ref_clk);
         #1;
         chk("final_duty0", 16'h1000, final_duty[15:0]);
      end
      $display("test ramp done");
   endtask
   task automatic t_regulator();
      @(posedge ref_clk);
      manual_enable <= 2'b11;
      regulator_hot_bind <= 4'b0001;
      wr(8'h0E, 8'h80);
      wr(8'h0F, 8'h20);
      wait_duty(1, 16'h2080, 20);
      wait_duty(0, 16'h0010, 20);
      chk("spinup_active", 16'h0000, {14'h0, spinup_active});
      rd(8'h0B, 8'h20);
      @(posedge ref_clk);
      regulator_hot <= 2'b01;
      wait_duty(0, 16'h0110, 20);
      wait_duty(0, 16'h0210, 40);
      chk("final_duty1", 16'h2080, final_duty[31:16]);
      @(posedge ref_clk);
      regulator_hot <= 2'b00;
      wait_duty(0, 16'h0010, 100);
      $display("test regulator done");
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_spinup();
      t_override();
      t_ramp();
      t_regulator();
      give_verdict();
   end
endmodule
`default_nettype wire
